// ### hw/dgpio_top.sv
`timescale 1ns/1ps
// What this block does
// R1: Port C latch, software RW, reset keeps
// R2: Port D latch, software RW, reset keeps
// R3: Port C direction 1 drives, 0 floats
// R4: Port D direction 1 drives, 0 floats
// R5: Reset clears port C direction
// R6: Reset clears port D direction
// R7: Port C read: latch if output, else pin
// R8: Port D read: latch if output, else pin
// R9: Latch writes accepted whatever direction
// R10: Input pin unaffected by latch write
// R11: SPI enable takes port C pins 2-5
// R12: IR serial enable takes pins 6, 7
// R13: Port C pin 0 always feeds interrupt
// R14: Pin 0 pullup on unless disable set
// R15: Keypad enable marks port D pins
// R16: Software presets C data before output
// R17: Software presets D data before output
// R18: Software sets unbonded pins as outputs
// R19: Registers kept and restored after override
// R20: Writes land at access edge, pins next
`include "dgpio_defines.svh"

module dgpio_top (
   input  wire logic                   clk_sys_in,
   input  wire logic                   rst_in,
   // APB slave
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [11:0]            paddr,
   input  wire logic [31:0]            pwdata,
   output logic      [31:0]            prdata,
   output logic                        pready,
   output logic                        pslverr,
   // Port C pins
   input  wire logic [7:0]             port_c_pin_in,
   output logic      [7:0]             port_c_pin_out,
   output logic      [7:0]             port_c_pin_oe_out,
   output logic                        port_c0_pullup_out,
   // Port D pins
   input  wire logic [7:0]             port_d_pin_in,
   output logic      [7:0]             port_d_pin_out,
   output logic      [7:0]             port_d_pin_oe_out,
   // SPI peripheral side, pins 2..5
   input  wire logic [3:0]             spi_pin_out_in,
   input  wire logic [3:0]             spi_pin_oe_in,
   output logic      [3:0]             spi_pin_in_out,
   output logic                        serial_periph_enable_out,
   // IR serial peripheral side
   input  wire logic                   ir_serial_transmit_line_in,
   output logic                        ir_serial_receive_line_out,
   output logic                        ir_serial_enable_out,
   // Interrupt and keypad routing
   output logic                        second_external_interrupt_out,
   input  wire logic [7:0]             keypad_irq_enable_bits_in,
   output logic      [7:0]             keypad_irq_inputs_out
);
   import dgpio_pkg::*;

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   dgpio_byte_t      c_latch_q, c_latch_d;
   dgpio_byte_t      d_latch_q, d_latch_d;
   dgpio_byte_t      c_dir_q, c_dir_d;
   dgpio_byte_t      d_dir_q, d_dir_d;
   logic [2:0]       pctl_q, pctl_d;
   logic [31:0]      rdata_q, rdata_d;
   logic             err_q, err_d;
   dgpio_bus_state_t st_q, st_d;
   dgpio_byte_t      c_sync;
   dgpio_byte_t      d_sync;
   logic             wr_fire;
   logic             rd_fire;
   logic [3:0]       idx;
   logic             mapped;

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   dgpio_pin_sync #(.WIDTH(8)) u_sync_c (
      .clk_sys_in (clk_sys_in),
      .rst_in     (rst_in),
      .async_in   (port_c_pin_in),
      .sync_out   (c_sync)
   );

   dgpio_pin_sync #(.WIDTH(8)) u_sync_d (
      .clk_sys_in (clk_sys_in),
      .rst_in     (rst_in),
      .async_in   (port_d_pin_in),
      .sync_out   (d_sync)
   );

   // Per-bit readback select, used for both ports
   function automatic dgpio_byte_t mix_read(input dgpio_byte_t dir,
                                            input dgpio_byte_t lat,
                                            input dgpio_byte_t pin);
      mix_read = (dir & lat) | (~dir & pin);
   endfunction

   // ------------------------------------------------------------
   // APB decode: one wait state, answer in access cycle 2
   // ------------------------------------------------------------
   assign idx    = paddr[5:2];
   assign mapped = (paddr[11:6] == 6'h00) && (paddr[1:0] == 2'b00) &&
                   (idx >= `DGPIO_IDX_PORT_C_LATCH) &&
                   (idx <= `DGPIO_IDX_PERIPH_CTRL);
   assign wr_fire = (st_q == DGPIO_ACCESS) && psel && penable && pwrite;
   assign rd_fire = (st_q == DGPIO_ACCESS) && psel && penable && !pwrite;

   // Bus state: IDLE until access phase, ACCESS gives pready
   always_comb begin
      st_d = st_q;
      unique case (st_q)
         DGPIO_IDLE: begin
            if (psel && penable) begin
               st_d = DGPIO_ACCESS;
            end
         end
         DGPIO_ACCESS: begin
            st_d = DGPIO_IDLE;
         end
         default: begin
            st_d = DGPIO_IDLE;
         end
      endcase
   end

   // Register writes, accepted whatever the direction bits
   always_comb begin
      c_latch_d = c_latch_q;
      d_latch_d = d_latch_q;
      c_dir_d   = c_dir_q;
      d_dir_d   = d_dir_q;
      pctl_d    = pctl_q;
      if (wr_fire && mapped) begin // R20
         unique case (idx)
            `DGPIO_IDX_PORT_C_LATCH: c_latch_d = pwdata[7:0]; // R1 R9
            `DGPIO_IDX_PORT_D_LATCH: d_latch_d = pwdata[7:0]; // R2 R9
            `DGPIO_IDX_PORT_C_DIR:   c_dir_d   = pwdata[7:0]; // R3
            `DGPIO_IDX_PORT_D_DIR:   d_dir_d   = pwdata[7:0]; // R4
            default:                 pctl_d    = pwdata[2:0];
         endcase
      end
   end

   // Read data registered one edge before the completing edge
   always_comb begin
      rdata_d = 32'h0000_0000;
      err_d   = 1'b0;
      if (psel && penable && (st_q == DGPIO_IDLE)) begin
         err_d = !mapped;
         if (!pwrite && mapped) begin
            unique case (idx)
               `DGPIO_IDX_PORT_C_LATCH:
                  rdata_d[7:0] = mix_read(c_dir_q, c_latch_q, c_sync); // R7
               `DGPIO_IDX_PORT_D_LATCH:
                  rdata_d[7:0] = mix_read(d_dir_q, d_latch_q, d_sync); // R8
               `DGPIO_IDX_PORT_C_DIR:   rdata_d[7:0] = c_dir_q;
               `DGPIO_IDX_PORT_D_DIR:   rdata_d[7:0] = d_dir_q;
               default:                 rdata_d[2:0] = pctl_q;
            endcase
         end
      end
   end

   // Latches have no reset: contents survive a system reset
   always_ff @(posedge clk_sys_in) begin
      c_latch_q <= c_latch_d; // R1
      d_latch_q <= d_latch_d; // R2
   end

   // Control state with reset
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         c_dir_q <= `DGPIO_DIR_RESET; // R5
         d_dir_q <= `DGPIO_DIR_RESET; // R6
         pctl_q  <= `DGPIO_PC_RESET;
         rdata_q <= 32'h0000_0000;
         err_q   <= 1'b0;
         st_q    <= DGPIO_IDLE;
      end else begin
         c_dir_q <= c_dir_d;
         d_dir_q <= d_dir_d;
         pctl_q  <= pctl_d;
         rdata_q <= rdata_d;
         err_q   <= err_d;
         st_q    <= st_d;
      end
   end

   assign pready  = (st_q == DGPIO_ACCESS);
   assign prdata  = rdata_q;
   assign pslverr = pready && err_q;

   // ------------------------------------------------------------
   // Pin muxing: peripherals override, registers left intact
   // ------------------------------------------------------------
   logic spi_en;
   logic ir_en;
   assign spi_en = pctl_q[`DGPIO_PC_SPI_EN_BIT];
   assign ir_en  = pctl_q[`DGPIO_PC_IR_EN_BIT];

   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_portc
         if (gi >= `DGPIO_SPI_LO && gi <= `DGPIO_SPI_HI) begin : g_spi
            // SPI owns the pin while enabled
            assign port_c_pin_out[gi] = spi_en ? // R11 R19
               spi_pin_out_in[gi-`DGPIO_SPI_LO] : c_latch_q[gi];
            assign port_c_pin_oe_out[gi] = spi_en ? // R11
               spi_pin_oe_in[gi-`DGPIO_SPI_LO] : c_dir_q[gi];
         end else if (gi == `DGPIO_IR_TX_PIN) begin : g_irtx
            assign port_c_pin_out[gi] = ir_en ? // R12 R19
               ir_serial_transmit_line_in : c_latch_q[gi];
            assign port_c_pin_oe_out[gi] = ir_en | c_dir_q[gi]; // R12
         end else if (gi == `DGPIO_IR_RX_PIN) begin : g_irrx
            assign port_c_pin_out[gi]    = c_latch_q[gi];
            assign port_c_pin_oe_out[gi] = !ir_en && c_dir_q[gi]; // R12
         end else begin : g_gp
            assign port_c_pin_out[gi]    = c_latch_q[gi];
            assign port_c_pin_oe_out[gi] = c_dir_q[gi]; // R3 R10
         end
      end
   endgenerate

   assign port_d_pin_out    = d_latch_q;
   assign port_d_pin_oe_out = d_dir_q; // R4 R10

   // Peripheral inputs take the synchronised pin levels
   assign spi_pin_in_out = c_sync[`DGPIO_SPI_HI:`DGPIO_SPI_LO];
   assign ir_serial_receive_line_out = c_sync[`DGPIO_IR_RX_PIN];
   assign serial_periph_enable_out   = spi_en;
   assign ir_serial_enable_out       = ir_en;
   assign second_external_interrupt_out = c_sync[0]; // R13
   assign port_c0_pullup_out =
      !pctl_q[`DGPIO_PC_PULLUP_DIS]; // R14
   // Gated keypad inputs
   assign keypad_irq_inputs_out = d_sync & keypad_irq_enable_bits_in; // R15

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   property p_dir_reset;
      @(posedge clk_sys_in) $fell(rst_in) |->
         (c_dir_q == 8'h00) && (d_dir_q == 8'h00);
   endproperty
   a_dir_reset: assert property (p_dir_reset) // R5 R6
      else $error("direction not cleared by reset");

   property p_c_write;
      @(posedge clk_sys_in) disable iff (rst_in)
         wr_fire && mapped && idx == `DGPIO_IDX_PORT_C_DIR
         ##1 !spi_en && !ir_en |-> port_c_pin_oe_out == $past(pwdata[7:0]);
   endproperty
   a_c_write: assert property (p_c_write) // R20 R3
      else $error("port C direction write not at pins");

   property p_d_latch;
      @(posedge clk_sys_in) disable iff (rst_in)
         wr_fire && mapped && idx == `DGPIO_IDX_PORT_D_LATCH |=>
         port_d_pin_out == $past(pwdata[7:0]);
   endproperty
   a_d_latch: assert property (p_d_latch) // R2 R9
      else $error("port D latch write lost");

   property p_d_read;
      @(posedge clk_sys_in) disable iff (rst_in)
         rd_fire && mapped && idx == `DGPIO_IDX_PORT_D_LATCH |->
         prdata[7:0] == $past(mix_read(d_dir_q, d_latch_q, d_sync));
   endproperty
   a_d_read: assert property (p_d_read) // R8
      else $error("port D readback wrong");

   property p_spi;
      @(posedge clk_sys_in) disable iff (rst_in)
         spi_en |-> port_c_pin_oe_out[5:2] == spi_pin_oe_in;
   endproperty
   a_spi: assert property (p_spi) // R11
      else $error("SPI override missing");

   property p_ready;
      @(posedge clk_sys_in) disable iff (rst_in)
         psel && penable && !pready |-> ##1 pready;
   endproperty
   a_ready: assert property (p_ready) // R20
      else $error("pready late");

   property p_pullup;
      @(posedge clk_sys_in) disable iff (rst_in)
         wr_fire && mapped && idx == `DGPIO_IDX_PERIPH_CTRL &&
         pwdata[`DGPIO_PC_PULLUP_DIS] |=> !port_c0_pullup_out;
   endproperty
   a_pullup: assert property (p_pullup) // R14
      else $error("pullup not disabled");

   property p_second_external_interrupt;
      @(posedge clk_sys_in) disable iff (rst_in)
         // Start only where reset sampled low: syncs were cleared before
         !rst_in |-> ##2
         second_external_interrupt_out == $past(port_c_pin_in[0], 2);
   endproperty
   a_second_external_interrupt: assert property (p_second_external_interrupt) // R13
      else $error("pin 0 not routed to interrupt");
endmodule

// ### hw/dgpio_defines.svh
`ifndef DGPIO_DEFINES_SVH
`define DGPIO_DEFINES_SVH

// Register word indices; the byte address is four times the index
`define DGPIO_IDX_PORT_C_LATCH 4'h2
`define DGPIO_IDX_PORT_D_LATCH 4'h3
`define DGPIO_IDX_PORT_C_DIR   4'h4
`define DGPIO_IDX_PORT_D_DIR   4'h5
`define DGPIO_IDX_PERIPH_CTRL  4'h6

// Peripheral control register field positions
`define DGPIO_PC_SPI_EN_BIT    0
`define DGPIO_PC_IR_EN_BIT     1
`define DGPIO_PC_PULLUP_DIS    2

// Reset values
`define DGPIO_DIR_RESET        8'h00
`define DGPIO_PC_RESET         3'h0

// Port C pin positions taken over by peripherals
`define DGPIO_SPI_LO           2
`define DGPIO_SPI_HI           5
`define DGPIO_IR_TX_PIN        6
`define DGPIO_IR_RX_PIN        7

`endif

// ### hw/dgpio_pkg.sv
package dgpio_pkg;
   typedef logic [7:0] dgpio_byte_t;
   typedef enum logic [1:0] {
      DGPIO_IDLE   = 2'b01,
      DGPIO_ACCESS = 2'b10
   } dgpio_bus_state_t;
endpackage

// ### hw/dgpio_pin_sync.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Two-stage synchroniser for a group of pins
// ---------------------------------------------------------------
module dgpio_pin_sync #(
   parameter int WIDTH = 8
) (
   input  wire logic             clk_sys_in,
   input  wire logic             rst_in,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] meta_d;
   logic [WIDTH-1:0] sync_q;
   logic [WIDTH-1:0] sync_d;

   // First stage only feeds second stage
   always_comb begin
      meta_d = async_in;
      sync_d = meta_q;
   end

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign sync_out = sync_q;
endmodule

// ### sim/dgpio_board_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Board side of one 8-bit port
// ---------------------------------------------------------------
module dgpio_board_model (
   input  wire logic       clk_sys_in,
   input  wire logic [7:0] dev_out_in,
   input  wire logic [7:0] dev_oe_in,
   input  wire logic [7:0] ext_val_in,
   input  wire logic [7:0] ext_en_in,
   input  wire logic [7:0] pullup_in,
   output logic      [7:0] level_out
);
   logic [7:0] float_q = 8'h55;
   // Floating nets toggle so a stale value never reads as valid
   always_ff @(posedge clk_sys_in) begin
      float_q <= ~float_q;
   end
   // Device buffer wins, then board driver, pullup, float
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (dev_oe_in[i]) begin
            level_out[i] = dev_out_in[i];
         end else if (ext_en_in[i]) begin
            level_out[i] = ext_val_in[i];
         end else if (pullup_in[i]) begin
            level_out[i] = 1'b1;
         end else begin
            level_out[i] = float_q[i];
         end
      end
   end
endmodule

// ### sim/test_dual_gpio_port_c_d.sv
`timescale 1ns/1ps
`include "dgpio_defines.svh"
module test_dual_gpio_port_c_d;
   localparam logic [11:0] LC = 12'(`DGPIO_IDX_PORT_C_LATCH) << 2;
   localparam logic [11:0] LD = 12'(`DGPIO_IDX_PORT_D_LATCH) << 2;
   localparam logic [11:0] DC = 12'(`DGPIO_IDX_PORT_C_DIR) << 2;
   localparam logic [11:0] DD = 12'(`DGPIO_IDX_PORT_D_DIR) << 2;
   localparam logic [11:0] PC = 12'(`DGPIO_IDX_PERIPH_CTRL) << 2;
   logic        clk_sys_in = 0, rst_in = 1;
   logic        psel = 0, penable = 0, pwrite = 0, pready, pslverr;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata;
   logic [7:0]  c_lvl, c_out, c_oe, d_lvl, d_out, d_oe, kb_out;
   logic [7:0]  kb_in = 8'h0f;
   logic [7:0]  c_val = 8'h3c, c_en = 8'hfe, d_val = 8'hc3, d_en = 8'hff;
   logic [3:0]  spi_o = 4'ha, spi_oe = 4'hf, spi_i;
   logic        pu, ir_tx = 1, ir_rx, serial_periph_enable, ire, second_external_interrupt;
   int          err_count = 0, checks = 0;
   // Clock at 125 MHz
   always #4 clk_sys_in = ~clk_sys_in;
   dgpio_top DUT (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .port_c_pin_in(c_lvl), .port_c_pin_out(c_out),
      .port_c_pin_oe_out(c_oe), .port_c0_pullup_out(pu),
      .port_d_pin_in(d_lvl), .port_d_pin_out(d_out),
      .port_d_pin_oe_out(d_oe), .spi_pin_out_in(spi_o),
      .spi_pin_oe_in(spi_oe), .spi_pin_in_out(spi_i),
      .serial_periph_enable_out(serial_periph_enable), .ir_serial_transmit_line_in(ir_tx),
      .ir_serial_receive_line_out(ir_rx), .ir_serial_enable_out(ire),
      .second_external_interrupt_out(second_external_interrupt),
      .keypad_irq_enable_bits_in(kb_in), .keypad_irq_inputs_out(kb_out));
   dgpio_board_model u_brd_c (.clk_sys_in(clk_sys_in), .dev_out_in(c_out),
      .dev_oe_in(c_oe), .ext_val_in(c_val), .ext_en_in(c_en),
      .pullup_in({7'h00, pu}), .level_out(c_lvl));
   dgpio_board_model u_brd_d (.clk_sys_in(clk_sys_in), .dev_out_in(d_out),
      .dev_oe_in(d_oe), .ext_val_in(d_val), .ext_en_in(d_en),
      .pullup_in(8'h00), .level_out(d_lvl));
   // ---------------------------------------------------------------
   // Bus and compare tasks
   // ---------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] e, g);
      checks++;
      if (g !== e) begin
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
         err_count++;
      end
   endtask
   // Called just after a rising edge; request held until pready is
   // seen high at a rising edge, then one idle edge before returning
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic er);
      int n;
      n = 0;
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk_sys_in);
      penable <= 1;
      do begin
         @(posedge clk_sys_in);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      er = pslverr;
      if (n >= 50) chk("pready", 1, 0);
      psel <= 0;
      penable <= 0;
      @(posedge clk_sys_in);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1, a, d, r, e);
   endtask
   task automatic rd(input string nm, input logic [11:0] a,
                     input logic [31:0] x);
      logic [31:0] r;
      logic        e;
      apb(0, a, 0, r, e);
      chk(nm, x, r);
      chk("pslverr", 0, e);
   endtask
   task automatic settle();
      repeat (3) @(posedge clk_sys_in);
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // Watchdog far beyond the fewer than two hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge clk_sys_in);
      err_count++;
      summarize();
   end
   // ---------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------
   initial begin
      logic [31:0] r;
      logic        e;
      repeat (8) @(posedge clk_sys_in);
      rst_in <= 0;
      rd("dir_c", DC, 0);
      rd("dir_d", DD, 0);
      chk("oe_c", 0, c_oe);
      chk("oe_d", 0, d_oe);
      chk("pullup", 1, pu);
      chk("second_external_interrupt_pulled", 1, second_external_interrupt);
      wr(PC, 32'h1 << `DGPIO_PC_PULLUP_DIS);
      chk("pullup_off", 0, pu);
      c_en <= 8'hff;
      settle();
      chk("second_external_interrupt_low", 0, second_external_interrupt);
      wr(PC, 0);
      $display("test reset_and_irq done");
      wr(LC, 32'ha5);
      settle();
      chk("oe_c_in", 0, c_oe);
      rd("pin_c", LC, 32'h3c);
      wr(DC, 32'h0f);
      chk("oe_c", 8'h0f, c_oe);
      chk("out_c", 4'h5, c_out[3:0]);
      settle();
      rd("mix_c", LC, 32'h35);
      $display("test port_c done");
      wr(LD, 32'h5a);
      wr(DD, 32'hf0);
      chk("oe_d", 8'hf0, d_oe);
      chk("out_d", 4'h5, d_out[7:4]);
      settle();
      rd("mix_d", LD, 32'h53);
      chk("keypad", 8'h03, kb_out);
      $display("test port_d done");
      c_val <= 8'hbc;
      wr(PC, 32'h3);
      chk("spe", 1, serial_periph_enable);
      chk("ire", 1, ire);
      chk("oe_ovr", 8'h7f, c_oe);
      chk("out_ovr", 5'h1a, c_out[6:2]);
      settle();
      chk("ir_rx", 1, ir_rx);
      chk("spi_in", 4'ha, spi_i);
      wr(DC, 0);
      rd("dir_ovr", DC, 0);
      wr(DC, 32'h0f);
      wr(PC, 0);
      chk("oe_back", 8'h0f, c_oe);
      chk("out_back", 4'h5, c_out[3:0]);
      $display("test override done");
      @(posedge clk_sys_in);
      rst_in <= 1;
      repeat (2) @(posedge clk_sys_in);
      rst_in <= 0;
      rd("dir_c_rst", DC, 0);
      rd("dir_d_rst", DD, 0);
      wr(DC, 32'hff);
      wr(DD, 32'hff);
      rd("lat_c_kept", LC, 32'ha5);
      rd("lat_d_kept", LD, 32'h5a);
      $display("test latch_keep done");
      apb(0, 12'h040, 0, r, e);
      chk("err_rd", 1, e);
      chk("data_rd", 0, r);
      apb(1, 12'h044, 32'hff, r, e);
      chk("err_wr", 1, e);
      $display("test unmapped done");
      summarize();
   end
endmodule
